/* File: audio_in_map.svh */
// offsets, fields, reset values and timing counts of the serial audio input monitor
//
// Overview of operation
// - device is clock slave; all clocks external
// - bit clock must be 32, 48 or 64 fs
// - processing clock from master clock, else oscillator
// - processing clock is 512 times switching rate
// - rates autodetected without software help
// - internal oscillator times clock error detection
// - on clock error: mute first, then oscillator
// - stable clocks: autodetect and resume automatically
// - default recovery restores volume in one step
// - volume setting selects gradual ramp recovery
// - 16, 20, 24 bit I2S, LJ, RJ
// - I2S: frame low left, high right
// - I2S: first bit one bit clock late
// - MSB first, sampled on bit clock rise
// - I2S: trailing slot bits ignored
// - samples are two's complement signed values
// - LJ and RJ: frame high left, low right
// - LJ: MSB with frame edge, no delay
// - RJ: LSB last; leading bits ignored
`ifndef AUDIO_IN_MAP_SVH
`define AUDIO_IN_MAP_SVH

`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_PERIOD 5'h08
`define REG_MCLK 5'h0c
`define REG_LEFT 5'h10
`define REG_RIGHT 5'h14

`define CTRL_FMT_RST 2'h0
`define CTRL_WL_RST 2'h2
`define CTRL_SOFT_RST 1'h0
`define CTRL_STEP_RST 8'h01

`define RATIO_32 7'h20
`define RATIO_48 7'h30
`define RATIO_64 7'h40

`define CLK_PERIOD_NS 50
`define LR_TO_NS 150000
`define LR_TO_CYC (`LR_TO_NS / `CLK_PERIOD_NS)
`define MCLK_TO_NS 4000
`define MCLK_TO_CYC (`MCLK_TO_NS / `CLK_PERIOD_NS)
`define PER_TOL 16'h0008
`define STABLE_FRAMES 3'h4
`define SW_DIV 512
`define GAIN_UNITY 8'h80

`endif

/* File: audio_in_pkg.sv */
// types shared by the serial audio input monitor
package audio_in_pkg;
	typedef enum logic [1:0] {
		FMT_I2S = 2'b00,
		FMT_LJ = 2'b01,
		FMT_RJ = 2'b10
	} fmt_t;
	typedef enum logic [1:0] {
		WL_16 = 2'b00,
		WL_20 = 2'b01,
		WL_24 = 2'b10
	} wl_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_MUTE = 2'b01,
		ST_LIMP = 2'b10,
		ST_RAMP = 2'b11
	} state_t;
endpackage

/* File: audio_serial_input_clock_monitor.sv */
// serial audio slave input with clock monitor, mute control and register slave
`include "audio_in_map.svh"
module audio_serial_input_clock_monitor
	import audio_in_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic mclk,
	input wire logic bclk,
	input wire logic lrclk,
	input wire logic serial_audio_in,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [23:0] left_sample,
	output logic [23:0] right_sample,
	output logic sample_valid,
	output logic [7:0] volume_gain,
	output logic pll_ref_osc,
	output logic switch_tick
);
	logic [3:0] lvl, rise;
	logic mclk_rise, bclk_rise, lr_lvl, sd_lvl;

	// all three clocks and data come from the master and are resampled here
	pin_sync #(.W(4)) u_sync (
		.clk(clk),
		.srst(srst),
		.pins({serial_audio_in, lrclk, bclk, mclk}),
		.level(lvl),
		.rise(rise)
	);
	assign mclk_rise = rise[0];
	assign bclk_rise = rise[1];
	assign lr_lvl = lvl[2];
	assign sd_lvl = lvl[3];

	function automatic logic [6:0] wl_bits(input logic [1:0] c);
		case (c)
			WL_16: wl_bits = 7'h10;
			WL_20: wl_bits = 7'h14;
			default: wl_bits = 7'h18;
		endcase
	endfunction

	// left-aligned so the sign bit stays on top
	function automatic logic [23:0] align(input logic [31:0] a, input logic [1:0] c);
		case (c)
			WL_16: align = {a[15:0], 8'h00};
			WL_20: align = {a[19:0], 4'h0};
			default: align = a[23:0];
		endcase
	endfunction

	function automatic logic ratio_ok(input logic [6:0] n);
		ratio_ok = (n == `RATIO_32) || (n == `RATIO_48) || (n == `RATIO_64);
	endfunction

	// bus slave and control register
	logic waitrequest_q, waitrequest_d;
	logic [31:0] readdata_q, readdata_d;
	logic [1:0] fmt_q, fmt_d, wl_q, wl_d;
	logic soft_q, soft_d;
	logic [7:0] step_q, step_d;
	// shared state, declared ahead of the read mux
	state_t state_q, state_d;
	logic pll_ref_osc_q, pll_ref_osc_d;
	logic [7:0] gain_q, gain_d;
	logic [6:0] ratio_q, ratio_d;
	logic [15:0] per_q, per_d, mratio_q, mratio_d;
	logic [23:0] left_q, left_d, right_q, right_d;
	logic mclk_ok;

	always_comb begin
		waitrequest_d = 1'b1;
		readdata_d = readdata_q;
		fmt_d = fmt_q;
		wl_d = wl_q;
		soft_d = soft_q;
		step_d = step_q;
		if ((read || write) && waitrequest_q) begin
			// one wait cycle, then the answer
			waitrequest_d = 1'b0;
			case (address)
				`REG_CTRL: readdata_d = {16'h0000, step_q, 3'h0, soft_q, wl_q, fmt_q};
				`REG_STATUS: readdata_d = {17'h00000, ratio_q, 3'h0, gain_q == 8'h00, mclk_ok, pll_ref_osc_q, state_q};
				`REG_PERIOD: readdata_d = {16'h0000, per_q};
				`REG_MCLK: readdata_d = {16'h0000, mratio_q};
				`REG_LEFT: readdata_d = {8'h00, left_q};
				`REG_RIGHT: readdata_d = {8'h00, right_q};
				default: readdata_d = 32'h0000_0000;
			endcase
		end
		if (write && !waitrequest_q && address == `REG_CTRL) begin
			if (byteenable[0]) begin
				fmt_d = writedata[1:0];
				wl_d = writedata[3:2];
				soft_d = writedata[4];
			end
			if (byteenable[1]) begin
				step_d = writedata[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
			fmt_q <= `CTRL_FMT_RST;
			wl_q <= `CTRL_WL_RST;
			soft_q <= `CTRL_SOFT_RST;
			step_q <= `CTRL_STEP_RST;
		end else begin
			waitrequest_q <= waitrequest_d;
			readdata_q <= readdata_d;
			fmt_q <= fmt_d;
			wl_q <= wl_d;
			soft_q <= soft_d;
			step_q <= step_d;
		end
	end

	// deserialiser, stepped by bit clock rises
	logic lr_prev_q, lr_prev_d, flr_q, flr_d, frm, left_slot, accept;
	logic [31:0] acc_q, acc_d;
	logic [6:0] idx_q, idx_d, bcnt_q, bcnt_d;
	logic valid_q, valid_d;
	logic frame_evt;

	assign frame_evt = bclk_rise && lr_lvl && !lr_prev_q;

	always_comb begin
		lr_prev_d = lr_prev_q;
		flr_d = flr_q;
		acc_d = acc_q;
		idx_d = idx_q;
		bcnt_d = bcnt_q;
		ratio_d = ratio_q;
		left_d = left_q;
		right_d = right_q;
		valid_d = 1'b0;
		// i2s runs one bit late, so its frame level is taken one bit clock back
		frm = (fmt_q == FMT_I2S) ? lr_prev_q : lr_lvl;
		left_slot = (fmt_q == FMT_I2S) ? !flr_q : flr_q;
		accept = (fmt_q == FMT_RJ) || (idx_q < wl_bits(wl_q));
		if (bclk_rise) begin
			lr_prev_d = lr_lvl;
			if (frm != flr_q) begin
				flr_d = frm;
				if (left_slot) begin
					left_d = align(acc_q, wl_q);
				end else begin
					right_d = align(acc_q, wl_q);
					valid_d = 1'b1;
				end
				acc_d = {31'h0000_0000, sd_lvl};
				idx_d = 7'h01;
			end else begin
				if (accept) begin
					acc_d = {acc_q[30:0], sd_lvl};
				end
				if (idx_q != 7'h7f) begin
					idx_d = idx_q + 7'h01;
				end
			end
			// bit clocks per frame, counted between frame clock rises
			if (frame_evt) begin
				ratio_d = bcnt_q;
				bcnt_d = 7'h01;
			end else if (bcnt_q != 7'h7f) begin
				bcnt_d = bcnt_q + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lr_prev_q <= 1'b0;
			flr_q <= 1'b0;
			acc_q <= 32'h0000_0000;
			idx_q <= 7'h00;
			bcnt_q <= 7'h00;
			ratio_q <= 7'h00;
			left_q <= 24'h00_0000;
			right_q <= 24'h00_0000;
			valid_q <= 1'b0;
		end else begin
			lr_prev_q <= lr_prev_d;
			flr_q <= flr_d;
			acc_q <= acc_d;
			idx_q <= idx_d;
			bcnt_q <= bcnt_d;
			ratio_q <= ratio_d;
			left_q <= left_d;
			right_q <= right_d;
			valid_q <= valid_d;
		end
	end

	// clock monitor and mute sequencer, timed by the local oscillator clock
	logic [15:0] per_cnt_q, per_cnt_d, per_diff, mcnt_q, mcnt_d;
	logic [7:0] mto_q, mto_d;
	logic [2:0] good_cnt_q, good_cnt_d;
	logic [8:0] ramp_sum;
	logic lr_to, frame_good, err_now;

	always_comb begin
		per_cnt_d = (per_cnt_q != 16'hffff) ? per_cnt_q + 16'h0001 : per_cnt_q;
		per_d = per_q;
		mcnt_d = mclk_rise ? mcnt_q + 16'h0001 : mcnt_q;
		mratio_d = mratio_q;
		mto_d = mclk_rise ? 8'h00 : ((mto_q != 8'hff) ? mto_q + 8'h01 : mto_q);
		state_d = state_q;
		pll_ref_osc_d = pll_ref_osc_q;
		gain_d = gain_q;
		good_cnt_d = good_cnt_q;
		lr_to = per_cnt_q >= 16'(`LR_TO_CYC);
		mclk_ok = mto_q < 8'(`MCLK_TO_CYC);
		per_diff = (per_cnt_q > per_q) ? per_cnt_q - per_q : per_q - per_cnt_q;
		frame_good = ratio_ok(bcnt_q) && (per_diff <= `PER_TOL) && mclk_ok;
		err_now = lr_to || !mclk_ok || (frame_evt && !frame_good);
		ramp_sum = {1'b0, gain_q} + {1'b0, step_q};
		if (frame_evt) begin
			per_d = per_cnt_q;
			per_cnt_d = 16'h0001;
			mratio_d = mcnt_q;
			mcnt_d = 16'h0000;
		end
		case (state_q)
			ST_RUN: begin
				if (err_now) begin
					gain_d = 8'h00;
					state_d = ST_MUTE;
				end
			end
			ST_MUTE: begin
				// audio already silent when the loop reference moves
				pll_ref_osc_d = 1'b1;
				good_cnt_d = 3'h0;
				state_d = ST_LIMP;
			end
			ST_LIMP: begin
				if (err_now) begin
					good_cnt_d = 3'h0;
				end else if (frame_evt) begin
					if (good_cnt_q == `STABLE_FRAMES - 3'h1) begin
						pll_ref_osc_d = 1'b0;
						if (soft_q) begin
							state_d = ST_RAMP;
						end else begin
							gain_d = `GAIN_UNITY;
							state_d = ST_RUN;
						end
					end else begin
						good_cnt_d = good_cnt_q + 3'h1;
					end
				end
			end
			ST_RAMP: begin
				if (err_now) begin
					gain_d = 8'h00;
					state_d = ST_MUTE;
				end else if (frame_evt) begin
					// one step per frame keeps the ramp free of clicks
					if (ramp_sum >= {1'b0, `GAIN_UNITY}) begin
						gain_d = `GAIN_UNITY;
						state_d = ST_RUN;
					end else begin
						gain_d = ramp_sum[7:0];
					end
				end
			end
			default: begin
				state_d = ST_MUTE;
				gain_d = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			per_cnt_q <= 16'h0000;
			per_q <= 16'h0000;
			mcnt_q <= 16'h0000;
			mratio_q <= 16'h0000;
			mto_q <= 8'hff;
			state_q <= ST_LIMP;
			pll_ref_osc_q <= 1'b1;
			gain_q <= 8'h00;
			good_cnt_q <= 3'h0;
		end else begin
			per_cnt_q <= per_cnt_d;
			per_q <= per_d;
			mcnt_q <= mcnt_d;
			mratio_q <= mratio_d;
			mto_q <= mto_d;
			state_q <= state_d;
			pll_ref_osc_q <= pll_ref_osc_d;
			gain_q <= gain_d;
			good_cnt_q <= good_cnt_d;
		end
	end

	// switching-rate enable: the processing clock divided by 512
	logic [8:0] sw_cnt_q, sw_cnt_d;
	logic tick_q, tick_d, seen_q, seen_d;
	logic [9:0] gap_q, gap_d;

	always_comb begin
		sw_cnt_d = sw_cnt_q + 9'h001;
		tick_d = sw_cnt_q == 9'(`SW_DIV - 1);
		seen_d = seen_q || tick_q;
		gap_d = tick_q ? 10'h000 : gap_q + 10'h001;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sw_cnt_q <= 9'h000;
			tick_q <= 1'b0;
			seen_q <= 1'b0;
			gap_q <= 10'h000;
		end else begin
			sw_cnt_q <= sw_cnt_d;
			tick_q <= tick_d;
			seen_q <= seen_d;
			gap_q <= gap_d;
		end
	end

	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;
	assign left_sample = left_q;
	assign right_sample = right_q;
	assign sample_valid = valid_q;
	assign volume_gain = gain_q;
	assign pll_ref_osc = pll_ref_osc_q;
	assign switch_tick = tick_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_fault;
		state_q == ST_RUN && err_now;
	endsequence
	sequence s_recover;
		state_q == ST_LIMP && !err_now && frame_evt && good_cnt_q == `STABLE_FRAMES - 3'h1;
	endsequence

	a_bus_ack_once: assert property ((read || write) && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q)
		else $error("bus answer not a single cycle");
	a_ratio_bad_mute: assert property (frame_evt && !ratio_ok(bcnt_q) && state_q == ST_RUN |=> state_q == ST_MUTE && gain_q == 8'h00)
		else $error("bad bit clock ratio did not mute");
	a_mute_then_osc: assert property (s_fault |=> (gain_q == 8'h00 && !pll_ref_osc_q) ##1 pll_ref_osc_q)
		else $error("mute and oscillator switch out of order");
	a_osc_when_unstable: assert property (state_q == ST_LIMP |-> pll_ref_osc_q)
		else $error("loop not on oscillator while clocks unstable");
	a_hard_unmute: assert property (s_recover and !soft_q |=> state_q == ST_RUN && gain_q == `GAIN_UNITY && !pll_ref_osc_q)
		else $error("hard unmute did not restore volume");
	a_soft_unmute: assert property (s_recover and soft_q |=> state_q == ST_RAMP && gain_q == 8'h00 && !pll_ref_osc_q)
		else $error("soft unmute did not start ramp");
	a_ramp_step: assert property ($past(state_q) == ST_RAMP && $changed(gain_q) && gain_q != 8'h00
		|-> gain_q == `GAIN_UNITY || gain_q == $past(gain_q) + step_q)
		else $error("ramp step wrong");
	a_valid_single: assert property (sample_valid |=> !sample_valid)
		else $error("sample strobe longer than one cycle");
	a_switch_period: assert property (tick_q && seen_q |-> gap_q == 10'(`SW_DIV - 1))
		else $error("switching tick spacing wrong");
endmodule

/* File: audio_src.sv */
// behavioural clock master: mclk, bclk, lrclk and serial data
module audio_src
	import audio_in_pkg::*;
(
	input wire logic run,
	input wire logic mclk_on,
	input wire fmt_t fmt,
	input wire logic [6:0] ratio,
	input wire logic [4:0] wl_bits,
	input wire logic [23:0] left_word,
	input wire logic [23:0] right_word,
	output logic mclk,
	output logic bclk,
	output logic lrclk,
	output logic sdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		mclk = 1'b0;
		forever #100 mclk = mclk_on ? ~mclk : 1'b0;
	end
	initial begin
		int off;
		int idx;
		logic [23:0] w;
		bclk = 1'b0;
		lrclk = 1'b0;
		sdata = 1'b0;
		// odd offset keeps the link unrelated in phase to clk
		#37;
		forever begin
			if (!run) #400;
			else for (int ch = 0; ch < 2; ch++) begin
				w = ch ? right_word : left_word;
				lrclk = ch[0] ^ (fmt != FMT_I2S);
				off = fmt == FMT_I2S ? 1 : fmt == FMT_LJ ? 0 : ratio / 2 - wl_bits;
				for (int k = 0; k < ratio / 2; k++) begin
					idx = k - off;
					// unused slots carry the inverse, so stale bits never look right
					sdata = (idx >= 0 && idx < wl_bits) ? w[23 - idx] : ~sdata;
					#200 bclk = 1'b1;
					#200 bclk = 1'b0;
				end
			end
		end
	end
endmodule

/* File: pin_sync.sv */
// two-stage synchroniser with rise detect for asynchronous pins
module pin_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] pins,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_q, s2_q, s3_q;
	logic [W-1:0] s1_d, s2_d, s3_d;

	always_comb begin
		s1_d = pins;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	// edge taken from stages two and three, never from the metastable first stage
	assign level = s2_q;
	assign rise = s2_q & ~s3_q;
endmodule

/* File: tb_audio_serial_input_clock_monitor.sv */
// self-checking bench for the serial audio input monitor
module tb_audio_serial_input_clock_monitor
	import audio_in_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, srst, mclk, bclk, lrclk, serial_audio_in, read, write, waitrequest, sample_valid, pll_ref_osc;
	logic switch_tick;
	logic [4:0] address, wl_bits;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic [23:0] left_sample, right_sample, lw, rw, lft, rgt;
	logic [7:0] volume_gain;
	logic run, mclk_on;
	logic [6:0] ratio;
	fmt_t fmt;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;

	audio_serial_input_clock_monitor uut (.clk(clk), .srst(srst), .mclk(mclk), .bclk(bclk), .lrclk(lrclk),
		.serial_audio_in(serial_audio_in), .address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .left_sample(left_sample),
		.right_sample(right_sample), .sample_valid(sample_valid), .volume_gain(volume_gain),
		.pll_ref_osc(pll_ref_osc), .switch_tick(switch_tick));
	audio_src src (.run(run), .mclk_on(mclk_on), .fmt(fmt), .ratio(ratio), .wl_bits(wl_bits),
		.left_word(lw), .right_word(rw), .mclk(mclk), .bclk(bclk), .lrclk(lrclk), .sdata(serial_audio_in));

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bus(logic wr, logic [4:0] a, logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= wd;
		read <= ~wr;
		write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// answer due one cycle after the request is taken
		chk("bus answer", 2, n);
	endtask

	task automatic frame();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sample_valid !== 1'b1 && n < 4000);
		lft = left_sample;
		rgt = right_sample;
		chk("frame strobe", 1, sample_valid);
		@(posedge clk);
		chk("strobe width", 0, sample_valid);
	endtask

	task automatic lock(int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((pll_ref_osc !== 1'b0 || volume_gain !== 8'h80) && n < lim);
		chk("clock lock", 1, n < lim);
	endtask

	task automatic fmt_case(fmt_t f, logic [1:0] w, logic [6:0] r);
		logic [31:0] d;
		logic [23:0] m;
		@(posedge clk);
		fmt <= f;
		wl_bits <= 5'(16 + 4 * w);
		ratio <= r;
		lw <= {lw[22:0], lw[23]};
		bus(1, 5'h00, {16'h0, 8'h01, 4'h0, w, f}, d);
		repeat (3) frame();
		// only the top wl bits survive, the rest read zero
		m = ~(24'hffffff >> wl_bits);
		chk("left word", {8'h0, lw & m}, {8'h0, lft});
		chk("right word", {8'h0, rw & m}, {8'h0, rgt});
	endtask

	task automatic hard_case();
		int n;
		lock(8000);
		mclk_on <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (volume_gain !== 8'h00 && n < 200);
		chk("mute reached", 0, volume_gain);
		chk("mute before osc", 0, pll_ref_osc);
		@(posedge clk);
		chk("osc after mute", 1, pll_ref_osc);
		mclk_on <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (volume_gain === 8'h00 && n < 8000);
		chk("hard unmute", 8'h80, volume_gain);
		chk("osc released", 0, pll_ref_osc);
	endtask

	task automatic soft_case();
		logic [31:0] d;
		logic [7:0] g;
		int n;
		fmt <= FMT_I2S;
		wl_bits <= 5'd24;
		bus(1, 5'h00, 32'h0000_2018, d);
		// the swapped frame polarity moves the frame edge and must trip the monitor
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pll_ref_osc !== 1'b1 && n < 3000);
		chk("format change caught", 1, pll_ref_osc);
		g = 8'h00;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (volume_gain !== g) begin
				chk("ramp step", {24'h0, g + 8'h20}, volume_gain);
				g = volume_gain;
			end
		end while (g !== 8'h80 && n < 9000);
		chk("ramp end", 8'h80, g);
		// bad ratio from a running, unmuted state
		ratio <= 7'd40;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pll_ref_osc !== 1'b1 && n < 3000);
		chk("bad ratio caught", 1, pll_ref_osc);
		repeat (2) frame();
		bus(0, 5'h04, 0, d);
		chk("bad ratio seen", 32'd40, {25'h0, d[14:8]});
		ratio <= 7'd64;
		lock(9000);
	endtask

	task automatic status_case();
		logic [31:0] d;
		int n;
		lock(8000);
		bus(0, 5'h04, 0, d);
		chk("status run", 32'h0000_4008, d);
		bus(0, 5'h08, 0, d);
		chk("frame period", 32'd512, d);
		bus(1, 5'h04, 32'hffff_ffff, d);
		bus(0, 5'h04, 0, d);
		chk("status read only", 32'h0000_4008, d);
		// 5 MHz master clock over a 512-cycle frame
		bus(0, 5'h0c, 0, d);
		chk("mclk per frame", 32'd128, d);
		bus(0, 5'h10, 0, d);
		chk("left register", {8'h00, lw}, d);
		bus(0, 5'h14, 0, d);
		chk("right register", {8'h00, rw}, d);
		do @(posedge clk); while (switch_tick !== 1'b1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (switch_tick !== 1'b1 && n < 2000);
		chk("tick spacing", 512, n);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// bound set well above the expected run of about 30k cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		logic [31:0] d;
		srst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		byteenable = 4'hf;
		run = 1'b1;
		mclk_on = 1'b1;
		fmt = FMT_I2S;
		ratio = 7'd64;
		wl_bits = 5'd24;
		lw = 24'h9abcde;
		rw = 24'h35a5c3;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("gain at reset", 0, volume_gain);
		chk("osc at reset", 1, pll_ref_osc);
		bus(0, 5'h00, 0, d);
		chk("ctrl reset", 32'h0000_0108, d);
		bus(0, 5'h18, 0, d);
		chk("unmapped read", 0, d);
		fmt_case(FMT_LJ, 2'd0, 7'd32);
		fmt_case(FMT_RJ, 2'd1, 7'd48);
		for (int f = 0; f < 3; f++) begin
			for (int w = 0; w < 3; w++) begin
				fmt_case(fmt_t'(f), 2'(w), 7'd64);
			end
		end
		hard_case();
		soft_case();
		status_case();
		test_done();
	end
endmodule
